// [edd_diag_map.svh]
// ============================================================
// Purpose: Offsets, field positions, reset values and times
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   Definitions only
`ifndef EDD_DIAG_MAP_SVH
`define EDD_DIAG_MAP_SVH
// Register byte offsets
`define EDD_OFS_CMD       8'h00
`define EDD_OFS_CFG       8'h04
`define EDD_OFS_TEST      8'h08
`define EDD_OFS_STATUS    8'h0C
`define EDD_OFS_ERROR     8'h10
`define EDD_OFS_DEVICE    8'h14
`define EDD_OFS_SIG       8'h18
`define EDD_OFS_STATE     8'h1C
// Command register fields
`define EDD_CMD_GO        0
`define EDD_CMD_SRST      1
// Configuration register fields
`define EDD_CFG_DEV1      0
`define EDD_CFG_PKT       1
`define EDD_CFG_NIEN      2
`define EDD_CFG_DASP      3
`define EDD_CFG_DRIVE     4
`define EDD_CFG_W         5
// Self-test register fields
`define EDD_TST_DONE      7
`define EDD_TST_PASS      8
// Status, error and device fields
`define EDD_ST_BSY        7
`define EDD_ST_BSY_MSK    8'h80
`define EDD_ST_CLR_ATA    8'h0D
`define EDD_ST_CLR_PKT    8'h7D
`define EDD_ERR_D1        7
`define EDD_ERR_TIMEOUT   8'h7F
`define EDD_DEV_BIT       4
// Reset values
`define EDD_RST_STATUS    8'h00
`define EDD_RST_ERROR     8'h00
`define EDD_RST_CFG       5'h00
`define EDD_RST_SIG       16'h0000
// Bus encoding
`define EDD_HTRANS_NONSEQ 2'h2
// Protocol times, in their own units
`define EDD_T400_NS       400
`define EDD_T1_MS         1
`define EDD_T5_S          5
`define EDD_T6_S          6
`endif

// [edd_pkg.sv]
// ============================================================
// Purpose: Types shared by the diagnostic sequencer
// Assumes: Nothing
// Notes:   Constants live in edd_diag_map.svh
package edd_pkg;
  // Sequencer states, one-hot
  typedef enum logic [5:0]
  {
    EDD_IDLE   = 6'h01,
    EDD_REL    = 6'h02,
    EDD_PDWAIT = 6'h04,
    EDD_PDSAMP = 6'h08,
    EDD_NEGATE = 6'h10,
    EDD_POST   = 6'h20
  } edd_state_e;
  typedef logic [31:0] edd_word_t;  // Bus word
endpackage : edd_pkg

// [edd_tmr_if.sv]
// ============================================================
// Purpose: Carrier between sequencer and interval timer
// Assumes: One clock
// Notes:   Hits stay high until run drops
interface edd_tmr_if;
  logic run;        // Count since command write
  logic hit_400n;   // 400 ns passed
  logic hit_1ms;    // 1 ms passed
  logic hit_5s;     // 5 s passed
  logic hit_6s;     // 6 s passed
  modport ctl (output run, input hit_400n, hit_1ms, hit_5s, hit_6s);
  modport tmr (input run, output hit_400n, hit_1ms, hit_5s, hit_6s);
endinterface : edd_tmr_if

// [edd_timer.sv]
// ============================================================
// Purpose: Interval timer measured from the command write
// Assumes: run rises in the cycle after the command write
// Notes:   Counter saturates; hits are registered
module edd_timer #(
  parameter int CW       = 30,
  parameter int T400_CYC = 40,
  parameter int T1MS_CYC = 100000,
  parameter int T5S_CYC  = 500000000,
  parameter int T6S_CYC  = 600000000
) (
  input wire logic clk,
  input wire logic reset,
  edd_tmr_if.tmr   tif
);
  import edd_pkg::*;
  localparam int NH = 4;                        // Number of limits
  localparam int TC [NH] = '{T400_CYC, T1MS_CYC, T5S_CYC, T6S_CYC};
  logic [CW-1:0] cnt;                           // Cycles since start
  logic [NH-1:0] hit_v;                         // Limit reached

  // ============================================================
  // Counter
  // Clear while idle, saturate at the top
  always_ff @(posedge clk)
  begin
    if (reset || !tif.run)
      cnt <= '0;
    else if (cnt != '1)
      cnt <= cnt + 1'b1;
  end

  // ============================================================
  // Limit compare, one per interval
  for (genvar i = 0; i < NH; i++)
  begin : g_hit
    // Hit is seen TC cycles after run rose
    always_ff @(posedge clk)
    begin
      if (reset || !tif.run)
        hit_v[i] <= 1'b0;
      else if (cnt >= CW'(TC[i] - 1))
        hit_v[i] <= 1'b1;
    end
  end

  assign tif.hit_400n = hit_v[0];
  assign tif.hit_1ms  = hit_v[1];
  assign tif.hit_5s   = hit_v[2];
  assign tif.hit_6s   = hit_v[3];
endmodule : edd_timer

// [edd_diag.sv]
// ============================================================
// Purpose: Device side of the self-diagnostic command handshake
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   One sequencer serves either drive role, chosen by CFG
//
// Contract
// - RESET- abandons diagnostic, restarts hardware reset
// - SRST abandons diagnostic, restarts software reset
// - Drive 0 sets BSY, floats pins, starts test
// - No drive 1 seen: clear error bit 7
// - Drive 0 clears DEV, waits 1 ms
// - Sample PDIAG-; 6 s timeout sets bit 7
// - Posting: clear DEV, result into error bits
// - Features register left undefined
// - No PACKET: clear status bits 3,2,0
// - PACKET: clear 6,5,4,3,2,0, reset modes
// - PACKET: mode settings to saved or default
// - Drive 0 clears BSY, INTRQ if nIEN clear
// - Drive 1 sets BSY, floats pins, starts test
// - Drive 1 negates PDIAG-, clears DEV quickly
// - Drive 1 posts result, asserts PDIAG- if passed
// - Drive 1 finishes posting within 5 s
// - Drive 1 clears BSY, idles unselected, no interrupt
`include "edd_diag_map.svh"

module edd_diag #(
  parameter int          CLK_HZ   = 100000000,
  parameter int          T1MS_CYC = (`EDD_T1_MS * (CLK_HZ / 1000)),
  parameter int          T5S_CYC  = `EDD_T5_S * CLK_HZ,
  parameter int          T6S_CYC  = `EDD_T6_S * CLK_HZ,
  parameter int          CW       = 30,
  parameter logic [15:0] SIG_ATA  = 16'h0000,
  parameter logic [15:0] SIG_PKT  = 16'h0000
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         hsel,
  input  edd_pkg::edd_word_t haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  edd_pkg::edd_word_t hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output edd_pkg::edd_word_t hrdata,
  input  wire logic         hard_reset_n,
  input  wire logic         pdiag_n,
  output logic              pdiag_drv_n,
  output logic              pdiag_oe_n,
  output logic              intrq,
  output logic              intrq_oe_n,
  output logic              iordy_oe_n,
  output logic              dmarq_oe_n,
  output logic              dd_oe_n,
  output logic              selftest_start,
  output logic              mode_restore,
  output logic              hw_restart,
  output logic              sw_restart
);
  import edd_pkg::*;

  // 400 ns is a longest time: round down, never below one cycle
  localparam int T400_RAW = (`EDD_T400_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int T400_CYC = (T400_RAW < 1) ? 1 : T400_RAW;

  // ============================================================
  // Declarations
  edd_state_e             state;        // Sequencer state
  logic [1:0]             pin_raw;      // Pins from outside
  logic [2:0]             pin_sync [2]; // Three-stage synchronisers
  logic [1:0]             pin_flt;      // Agreed pin levels
  logic                   hw_prev;      // RESET- asserted last cycle
  logic                   hw_hold;      // RESET- asserted
  logic                   acc;          // Address phase taken
  logic                   wr_pend;      // Write data phase due
  logic [7:0]             wr_addr;      // Address of pending write
  edd_word_t              next_rdata;   // Read word for address
  logic                   go;           // Diagnostic command written
  logic                   srst;         // Soft reset written
  logic                   abort;        // Either reset seen
  logic                   rd_status;    // Status read taken
  logic [`EDD_CFG_W-1:0]  cfg;          // Role and option bits
  logic                   test_done;    // Self-test finished
  logic                   test_pass;    // Self-test passed
  logic [6:0]             test_code;    // Self-test result code
  logic [7:0]             status;       // Status register
  logic [7:0]             error;        // Error register
  logic                   dev_bit;      // DEV bit of device register
  logic [15:0]            sig;          // Signature values
  logic                   dev1;         // Acting as drive 1
  logic                   post_done;    // Posting may finish now
  logic [7:0]             clr_mask;     // Status bits cleared at post

  edd_tmr_if tif ();

  // ============================================================
  // Interval timer
  edd_timer #(
    .CW       (CW),
    .T400_CYC (T400_CYC),
    .T1MS_CYC (T1MS_CYC),
    .T5S_CYC  (T5S_CYC),
    .T6S_CYC  (T6S_CYC)
  ) u_timer (
    .clk   (clk),
    .reset (reset),
    .tif   (tif)
  );

  // ============================================================
  // Decode helpers
  // Word address match on the low byte
  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : is_ofs

  // ============================================================
  // Pin synchronisers
  assign pin_raw = {hard_reset_n, pdiag_n};

  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    // Level moves once stages two and three agree
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        pin_sync[g] <= 3'h7;
        pin_flt[g]  <= 1'b1;
      end
      else
      begin
        pin_sync[g] <= {pin_sync[g][1:0], pin_raw[g]};
        if (pin_sync[g][1] == pin_sync[g][2])
          pin_flt[g] <= pin_sync[g][2];
      end
    end
  end

  // ============================================================
  // Control decode
  assign hw_hold   = !pin_flt[1];
  assign acc       = hsel && hready && (htrans == `EDD_HTRANS_NONSEQ);
  assign go        = wr_pend && is_ofs(wr_addr, `EDD_OFS_CMD) && hwdata[`EDD_CMD_GO];
  assign srst      = wr_pend && is_ofs(wr_addr, `EDD_OFS_CMD) && hwdata[`EDD_CMD_SRST];
  assign abort     = hw_hold || srst;
  assign rd_status = acc && !hwrite && is_ofs(haddr[7:0], `EDD_OFS_STATUS);
  assign dev1      = cfg[`EDD_CFG_DEV1];
  // Drive 1 is forced to finish at the 5 s limit
  assign post_done = (state == EDD_POST) && (test_done || (dev1 && tif.hit_5s));
  // Status bits cleared depend on PACKET support
  assign clr_mask  = cfg[`EDD_CFG_PKT] ? `EDD_ST_CLR_PKT : `EDD_ST_CLR_ATA;

  // ============================================================
  // Bus slave
  // Address phase capture, write lands in the data phase
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= acc && hwrite;
      if (acc)
        wr_addr <= haddr[7:0];
    end
  end

  // Read word selection
  always_comb
  begin
    if (is_ofs(haddr[7:0], `EDD_OFS_CFG))
      next_rdata = {27'h0, cfg};
    else if (is_ofs(haddr[7:0], `EDD_OFS_TEST))
      next_rdata = {23'h0, test_pass, test_done, test_code};
    else if (is_ofs(haddr[7:0], `EDD_OFS_STATUS))
      next_rdata = {24'h000000, status};
    else if (is_ofs(haddr[7:0], `EDD_OFS_ERROR))
      next_rdata = {24'h000000, error};
    else if (is_ofs(haddr[7:0], `EDD_OFS_DEVICE))
      next_rdata = {27'h0, dev_bit, 4'h0};
    else if (is_ofs(haddr[7:0], `EDD_OFS_SIG))
      next_rdata = {16'h0000, sig};
    else if (is_ofs(haddr[7:0], `EDD_OFS_STATE))
      next_rdata = {26'h0, state};
    else
      next_rdata = 32'h00000000;  // Command and unmapped read zero
  end

  // Read data registered for the data phase; always ready, OKAY
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc && !hwrite)
        hrdata <= next_rdata;
    end
  end

  // ============================================================
  // Configuration register
  always_ff @(posedge clk)
  begin
    if (reset)
      cfg <= `EDD_RST_CFG;
    else if (wr_pend && is_ofs(wr_addr, `EDD_OFS_CFG))
      cfg <= hwdata[`EDD_CFG_W-1:0];
  end

  // ============================================================
  // Self-test result register
  // Cleared on command and on abandon, filled by the test engine
  always_ff @(posedge clk)
  begin
    if (reset || abort || (state == EDD_IDLE && go))
    begin
      test_done <= 1'b0;
      test_pass <= 1'b0;
      test_code <= 7'h00;
    end
    else if (wr_pend && is_ofs(wr_addr, `EDD_OFS_TEST))
    begin
      test_done <= hwdata[`EDD_TST_DONE];
      test_pass <= hwdata[`EDD_TST_PASS];
      test_code <= hwdata[6:0];
    end
  end

  // ============================================================
  // Sequencer
  always_ff @(posedge clk)
  begin
    if (reset || abort)
      state <= EDD_IDLE;  // Abandon on either reset
    else
    begin
      case (state)
        EDD_IDLE:
          if (go)
            state <= EDD_REL;
        // Pins already released; leave once 400 ns is up
        EDD_REL:
          if (tif.hit_400n)
          begin
            if (dev1)
              state <= EDD_NEGATE;
            else if (cfg[`EDD_CFG_DASP])
              state <= EDD_PDWAIT;
            else
              state <= EDD_POST;
          end
        // Hold off sampling until 1 ms after the command
        EDD_PDWAIT:
          if (tif.hit_1ms)
            state <= EDD_PDSAMP;
        // Poll until asserted or 6 s have passed
        EDD_PDSAMP:
          if (!pin_flt[0] || tif.hit_6s)
            state <= EDD_POST;
        EDD_NEGATE:
          state <= EDD_POST;
        EDD_POST:
          if (post_done)
            state <= EDD_IDLE;
        default:
          state <= EDD_IDLE;
      endcase
    end
  end

  // Timer runs from the command write until posting ends
  always_ff @(posedge clk)
  begin
    if (reset || abort)
      tif.run <= 1'b0;
    else if (state == EDD_IDLE && go)
      tif.run <= 1'b1;
    else if (post_done)
      tif.run <= 1'b0;
  end

  // ============================================================
  // Status register
  always_ff @(posedge clk)
  begin
    if (reset || abort)
      status <= `EDD_RST_STATUS;
    else if (state == EDD_IDLE && go)
      status[`EDD_ST_BSY] <= 1'b1;
    else if (post_done)
      status <= status & ~(clr_mask | `EDD_ST_BSY_MSK);
  end

  // ============================================================
  // Error register
  always_ff @(posedge clk)
  begin
    if (reset || abort)
      error <= `EDD_RST_ERROR;
    else if (state == EDD_REL && tif.hit_400n && !dev1 && !cfg[`EDD_CFG_DASP])
      error[`EDD_ERR_D1] <= 1'b0;
    else if (state == EDD_PDSAMP && !pin_flt[0])
      error[`EDD_ERR_D1] <= 1'b0;
    else if (state == EDD_PDSAMP && tif.hit_6s)
      error[`EDD_ERR_D1] <= 1'b1;
    else if (post_done && dev1)
      error <= test_done ? {1'b0, test_code} : `EDD_ERR_TIMEOUT;
    else if (post_done)
      error[6:0] <= test_code;
  end

  // ============================================================
  // Device register DEV bit and signature
  // Host writes select; diagnostic clears it early on
  always_ff @(posedge clk)
  begin
    if (reset || abort)
      dev_bit <= 1'b0;
    else if (state == EDD_PDWAIT || state == EDD_NEGATE || state == EDD_POST)
      dev_bit <= 1'b0;
    else if (state == EDD_IDLE && wr_pend && is_ofs(wr_addr, `EDD_OFS_DEVICE))
      dev_bit <= hwdata[`EDD_DEV_BIT];
  end

  // Signature loaded at posting; features are left untouched
  always_ff @(posedge clk)
  begin
    if (reset || abort)
      sig <= `EDD_RST_SIG;
    else if (post_done)
      sig <= cfg[`EDD_CFG_PKT] ? SIG_PKT : SIG_ATA;
  end

  // ============================================================
  // Pin drivers
  // Release on command, interrupt and PDIAG- at posting
  always_ff @(posedge clk)
  begin
    if (reset || abort)
    begin
      intrq       <= 1'b0;
      intrq_oe_n  <= 1'b1;
      pdiag_drv_n <= 1'b1;
      pdiag_oe_n  <= 1'b1;
      iordy_oe_n  <= 1'b1;
      dmarq_oe_n  <= 1'b1;
      dd_oe_n     <= 1'b1;
    end
    else if (state == EDD_IDLE && go)
    begin
      // Float everything the drive may own
      intrq       <= 1'b0;
      intrq_oe_n  <= 1'b1;
      pdiag_drv_n <= 1'b1;
      pdiag_oe_n  <= 1'b1;
      iordy_oe_n  <= 1'b1;
      dmarq_oe_n  <= 1'b1;
      dd_oe_n     <= 1'b1;
    end
    else if (state == EDD_NEGATE)
    begin
      pdiag_drv_n <= 1'b1;
      pdiag_oe_n  <= 1'b0;
    end
    else if (post_done && dev1)
    begin
      // Assert only after a pass; never interrupt
      pdiag_drv_n <= !(test_done && test_pass);
      intrq       <= 1'b0;
    end
    else if (post_done && !cfg[`EDD_CFG_NIEN])
    begin
      intrq       <= 1'b1;
      intrq_oe_n  <= 1'b0;
    end
    else if (state == EDD_IDLE)
    begin
      // Idle: other command logic may own the data pins
      iordy_oe_n  <= !cfg[`EDD_CFG_DRIVE];
      dmarq_oe_n  <= !cfg[`EDD_CFG_DRIVE];
      dd_oe_n     <= !cfg[`EDD_CFG_DRIVE];
      if (rd_status)
        intrq     <= 1'b0;           // Status read clears pending interrupt
    end
  end

  // ============================================================
  // Event pulses
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hw_prev        <= 1'b0;
      selftest_start <= 1'b0;
      mode_restore   <= 1'b0;
      hw_restart     <= 1'b0;
      sw_restart     <= 1'b0;
    end
    else
    begin
      hw_prev        <= hw_hold;
      selftest_start <= (state == EDD_IDLE) && go && !abort;
      mode_restore   <= post_done && cfg[`EDD_CFG_PKT];
      hw_restart     <= hw_hold && !hw_prev;
      sw_restart     <= srst && !hw_hold;
    end
  end

endmodule : edd_diag

// [edd_diag_monitor.sv]
// ============================================================
// Purpose: Port checker for the diagnostic sequencer
// Assumes: One clock, bound to edd_diag
// Notes:   Decodes the command write data phase itself
`include "edd_diag_map.svh"
module edd_mon #(
  parameter int T1MS_CYC = 200
) (
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          hsel,
  input edd_pkg::edd_word_t haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hready,
  input edd_pkg::edd_word_t hwdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic          hard_reset_n,
  input wire logic          pdiag_drv_n,
  input wire logic          pdiag_oe_n,
  input wire logic          intrq,
  input wire logic          intrq_oe_n,
  input wire logic          iordy_oe_n,
  input wire logic          dmarq_oe_n,
  input wire logic          dd_oe_n,
  input wire logic          selftest_start,
  input wire logic          mode_restore,
  input wire logic          hw_restart,
  input wire logic          sw_restart
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic cmd_dp;   // Data phase of a command write
  int   since_go; // Cycles since self-test start
  // ============================================================
  // Helper: command data phase and run length
  always_ff @(posedge clk)
  begin
    cmd_dp <= hsel && hready && htrans == `EDD_HTRANS_NONSEQ && hwrite
              && haddr[7:0] == `EDD_OFS_CMD;
    since_go <= (reset || selftest_start) ? 0 : since_go + 1;
  end
  // ============================================================
  // Assertions
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready");
  a_start_cause: assert property (selftest_start |-> $past(cmd_dp) && $past(hwdata[0]))
    else $error("self-test start without command");
  a_go_release: assert property (selftest_start |-> (dd_oe_n && iordy_oe_n && dmarq_oe_n
    && intrq_oe_n && pdiag_oe_n) [*8]) else $error("pins driven while busy");
  a_sw_abort: assert property (cmd_dp && hwdata[1] && hard_reset_n |=> sw_restart)
    else $error("reset write not honoured");
  a_hw_abort: assert property ($fell(hard_reset_n) |-> ##[2:5] hw_restart)
    else $error("reset pin not honoured");
  a_hw_release: assert property (hw_restart |-> ##1 intrq_oe_n && pdiag_oe_n)
    else $error("pins held after reset pin");
  a_neg_timely: assert property ($fell(pdiag_oe_n) |-> pdiag_drv_n && since_go < T1MS_CYC)
    else $error("late or wrong negation");
  a_intrq_drive: assert property ($rose(intrq) |-> !intrq_oe_n)
    else $error("interrupt raised undriven");
  a_one_role: assert property (!(!pdiag_oe_n && !intrq_oe_n))
    else $error("both role outputs driven");
  a_mode_pulse: assert property (mode_restore |-> !selftest_start ##1 !mode_restore)
    else $error("mode restore not a pulse");
  c_start: cover property (selftest_start);
  c_sw: cover property (sw_restart);
  c_mode: cover property (mode_restore);
endmodule : edd_mon

// [edd_peer.sv]
// ============================================================
// Purpose: Peer drive on the shared pass/fail line
// Assumes: Line pulled up; either party pulls low
// Notes:   Bench chooses the peer's test result
module edd_peer #(
  parameter int LAT = 50
) (
  input  wire logic clk,
  input  wire logic start,
  input  wire logic pass,
  input  wire logic dut_oe_n,
  input  wire logic dut_drv_n,
  output wire logic pdiag_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt  = 0;    // Cycles since command
  logic pull = 1'b0; // Own low drive
  // ============================================================
  // Negate at command, assert after test if passed
  always @(posedge clk)
  begin
    if (start)
      cnt <= 1;
    else if (cnt != 0 && cnt < LAT)
      cnt <= cnt + 1;
    pull <= !start && cnt == LAT && pass;
  end
  // Pull-up wins when nobody drives low
  assign pdiag_n = !(pull || (!dut_oe_n && !dut_drv_n));
endmodule : edd_peer

// [test_execute_diagnostic_protocol.sv]
// ============================================================
// Purpose: Self-checking bench for the diagnostic sequencer
// Assumes: Shortened interval parameters
// Notes:   Bus tasks act as host; edd_peer as other drive
`include "edd_diag_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_execute_diagnostic_protocol;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          T1MS  = 200;
  localparam int          T5S   = 1000;
  localparam int          T6S   = 1200;
  localparam logic [15:0] SIG_A = 16'h5A3C; // Arbitrary
  localparam logic [15:0] SIG_P = 16'hC3A5; // Arbitrary
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, hard_reset_n = 1, peer_go = 0, peer_pass = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize  = 3'h2;
  logic [3:0] seen   = 4'h0; // Caught pulses: hw, sw, mode, start
  edd_pkg::edd_word_t haddr = 0, hwdata = 0, hrdata, rd;
  logic hreadyout, hresp, pdiag_drv_n, pdiag_oe_n, intrq, intrq_oe_n, iordy_oe_n;
  logic dmarq_oe_n, dd_oe_n, selftest_start, mode_restore, hw_restart, sw_restart;
  wire logic pdiag_n; // Shared line
  int n_fail = 0, cmp_count = 0;
  always #5 clk = ~clk;
  always @(posedge clk) seen <= seen | {hw_restart, sw_restart, mode_restore, selftest_start};
  edd_diag #(.T1MS_CYC(T1MS), .T5S_CYC(T5S), .T6S_CYC(T6S), .SIG_ATA(SIG_A), .SIG_PKT(SIG_P)) DUT (
    .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .hard_reset_n, .pdiag_n, .pdiag_drv_n, .pdiag_oe_n, .intrq,
    .intrq_oe_n, .iordy_oe_n, .dmarq_oe_n, .dd_oe_n, .selftest_start, .mode_restore,
    .hw_restart, .sw_restart);
  edd_peer #(.LAT(50)) u_peer (.clk, .start(peer_go), .pass(peer_pass), .dut_oe_n(pdiag_oe_n),
    .dut_drv_n(pdiag_drv_n), .pdiag_n);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One single AHB-Lite word transfer
  task automatic bus(input logic [7:0] a, input logic w, input edd_pkg::edd_word_t d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= `EDD_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input edd_pkg::edd_word_t e);
    bus(a, 1'h0, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  task automatic go(input logic [4:0] cfg, input logic pass);
    bus(`EDD_OFS_CFG, 1'h1, {27'h0, cfg});
    peer_pass <= pass;
    @(negedge clk) seen = 4'h0;
    bus(`EDD_OFS_CMD, 1'h1, 32'h1);
    peer_go <= 1'h1;
    @(posedge clk);
    peer_go <= 1'h0;
  endtask : go
  task automatic post(input edd_pkg::edd_word_t t);
    bus(`EDD_OFS_TEST, 1'h1, t);
    cyc(2);
  endtask : post
  // Host polls until busy drops
  task automatic poll;
    rd = 32'h80;
    for (int i = 0; i < 20 && rd[7]; i++) bus(`EDD_OFS_STATUS, 1'h0, 32'h0);
    `CHK(rd[7], 1'h0)
  endtask : poll
  task automatic t_reset;
    rdchk(`EDD_OFS_STATE, 32'h01);
    rdchk(`EDD_OFS_ERROR, 32'h00);
    rdchk(8'h40, 32'h0);
    `CHK({intrq_oe_n, pdiag_oe_n, dd_oe_n}, 3'h7)
  endtask : t_reset
  task automatic t_d0_alone;
    go(5'h10, 1'h0);
    `CHK({iordy_oe_n, dmarq_oe_n, dd_oe_n}, 3'h7)
    rdchk(`EDD_OFS_STATUS, `EDD_ST_BSY_MSK);
    `CHK(seen[0], 1'h1)
    cyc(45);
    rdchk(`EDD_OFS_STATE, 32'h20);
    post(32'h95);
    for (int i = 0; i < 50 && intrq !== 1'b1; i++) @(posedge clk);
    `CHK(intrq, 1'h1)
    rdchk(`EDD_OFS_ERROR, 32'h15);
    rdchk(`EDD_OFS_SIG, {16'h0, SIG_A});
    rdchk(`EDD_OFS_STATUS, 32'h0);
  endtask : t_d0_alone
  task automatic t_d0_pass;
    bus(`EDD_OFS_DEVICE, 1'h1, 32'h10);
    go(5'h0C, 1'h1);
    cyc(100);
    rdchk(`EDD_OFS_DEVICE, 32'h0);
    rdchk(`EDD_OFS_STATE, 32'h04);
    cyc(2 * T1MS);
    rdchk(`EDD_OFS_STATE, 32'h20);
    post(32'h81);
    poll;
    rdchk(`EDD_OFS_ERROR, 32'h01);
    `CHK(intrq, 1'h0)
  endtask : t_d0_pass
  task automatic t_d0_late;
    go(5'h0A, 1'h0);
    cyc(T1MS + 100);
    rdchk(`EDD_OFS_STATE, 32'h08);
    cyc(T6S);
    rdchk(`EDD_OFS_STATE, 32'h20);
    post(32'h80);
    poll;
    rdchk(`EDD_OFS_ERROR, 32'h80);
    rdchk(`EDD_OFS_SIG, {16'h0, SIG_P});
    `CHK(seen[1], 1'h1)
  endtask : t_d0_late
  task automatic t_d1_pass;
    go(5'h01, 1'h0);
    cyc(60);
    `CHK({pdiag_oe_n, pdiag_drv_n, intrq_oe_n}, 3'h3)
    post(32'h185);
    rdchk(`EDD_OFS_ERROR, 32'h05);
    rdchk(`EDD_OFS_STATUS, 32'h0);
    `CHK({pdiag_n, intrq}, 2'h0)
  endtask : t_d1_pass
  task automatic t_d1_late;
    go(5'h01, 1'h0);
    cyc(T5S + 20);
    rdchk(`EDD_OFS_STATUS, 32'h0);
    rdchk(`EDD_OFS_ERROR, 32'h7F);
    `CHK(pdiag_n, 1'h1)
  endtask : t_d1_late
  task automatic t_srst;
    go(5'h0C, 1'h0);
    cyc(10);
    bus(`EDD_OFS_CMD, 1'h1, 32'h2);
    cyc(2);
    `CHK(seen[2], 1'h1)
    rdchk(`EDD_OFS_STATE, 32'h01);
    rdchk(`EDD_OFS_STATUS, 32'h0);
  endtask : t_srst
  task automatic t_hwrst;
    go(5'h01, 1'h0);
    cyc(50);
    hard_reset_n <= 1'h0;
    cyc(6);
    hard_reset_n <= 1'h1;
    cyc(6);
    `CHK({seen[3], pdiag_oe_n, intrq_oe_n}, 3'h7)
    rdchk(`EDD_OFS_STATE, 32'h01);
  endtask : t_hwrst
  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    cyc(5);
    reset <= 1'h0;
    t_reset;
    t_d0_alone;
    t_d0_pass;
    t_d0_late;
    t_d1_pass;
    t_d1_late;
    t_srst;
    t_hwrst;
    report_and_stop;
  end
  initial
  begin
    cyc(10000);
    n_fail++;
    report_and_stop;
  end
endmodule : test_execute_diagnostic_protocol
bind edd_diag edd_mon #(.T1MS_CYC(T1MS_CYC)) u_mon (.clk, .reset, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hreadyout, .hresp, .hard_reset_n, .pdiag_drv_n, .pdiag_oe_n,
  .intrq, .intrq_oe_n, .iordy_oe_n, .dmarq_oe_n, .dd_oe_n, .selftest_start, .mode_restore,
  .hw_restart, .sw_restart);
